// ===== hw/clou_defines.svh
// Constants of the compare latch and output unit
// Overview of operation
// - Both edges and high source bit set: each low-bit toggle by software captures once.
// - Mode-select bit cleared puts a channel in compare mode.
// - Counter reaching the latch value sets the flag and pulses the match signal.
// - Latches are hidden from software; data goes through the channel buffer.
// - Load timing 00 copies buffer into latch on each buffer write.
// - Load timing 01 copies when the counter counts to zero.
// - Load timing 10 copies at zero, or at old period value in up/down.
// - Load timing 11 copies when the counter counts to the old latch value.
// - Lowest channel of each group sets its load timing, except group setting 3.
// - Controlling load timing zero disables grouping; each latch loads on own write.
// - A group loads only after all its buffers were written and the event came.
// - Group field: none, pairs 1-2/3-4/5-6, triples 1-3/4-6, all under channel 1.
// - Each channel has an eight-mode output unit fed by channel and period matches.
// - Selected high-impedance function and pin high float all timer outputs.
// - Output changes on the clock edge; mode 0 follows the output bit.
// - Mode 000 output equals the software output bit, updated when written.
// - Mode 001 sets on match and holds until reset or another mode.
// - Mode 100 toggles on match; mode 101 resets on match and holds.
// - Modes 010/011/110/111: toggle/set/toggle/reset on match, then reset/reset/set/set on period.
// - In up/down counting matches act in both directions plus period match.
`ifndef CLOU_DEFINES_SVH
`define CLOU_DEFINES_SVH

`define CLOU_NCH            7
`define CLOU_DW             16
`define CLOU_AW             5
`define CLOU_ADDR_CTL_BASE  5'h00
`define CLOU_ADDR_BUF_BASE  5'h08
`define CLOU_ADDR_GLB       5'h10
`define CLOU_ZERO_WORD      16'h0000
`define CLOU_LD_IMM         2'h0
`define CLOU_LD_ZERO        2'h1
`define CLOU_LD_ZERO_PER    2'h2
`define CLOU_LD_OLD         2'h3
`define CLOU_GRP_NONE       2'h0
`define CLOU_GRP_PAIR       2'h1
`define CLOU_GRP_TRIPLE     2'h2
`define CLOU_GRP_ALL        2'h3
`define CLOU_CH_ZERO        3'h0
`define CLOU_CH_ONE         3'h1
`define CLOU_CH_THREE       3'h3
`define CLOU_CH_FOUR        3'h4
`define CLOU_MC_UPDOWN      2'h3
`define CLOU_EDGE_RISE      2'h1
`define CLOU_EDGE_FALL      2'h2
`define CLOU_EDGE_BOTH      2'h3
`define CLOU_SRC_A          2'h0
`define CLOU_SRC_B          2'h1
`define CLOU_SRC_GND        2'h2
`define CLOU_SRC_VCC        2'h3
`define CLOU_WF_OUTPUT      3'h0
`define CLOU_WF_SET         3'h1
`define CLOU_WF_TOG_RST     3'h2
`define CLOU_WF_SET_RST     3'h3
`define CLOU_WF_TOGGLE      3'h4
`define CLOU_WF_RESET       3'h5
`define CLOU_WF_TOG_SET     3'h6
`define CLOU_WF_RST_SET     3'h7

`endif

// ===== hw/clou_pkg.sv
// Types of the compare latch and output unit
`include "clou_defines.svh"

package clou_pkg;

  typedef struct packed {
    logic [1:0] edge_select;
    logic [1:0] input_source_select;
    logic       sync_to_timer_clock;
    logic [1:0] latch_load_timing;
    logic       sample_mode_select;
    logic [2:0] waveform_select;
    logic [1:0] spare;
    logic       input_level;
    logic       out_level;
    logic       channel_match_flag;
  } clou_ctl_t;

  typedef struct packed {
    logic [12:0] spare;
    logic        hiz_function;
    logic [1:0]  latch_group_select;
  } clou_glb_t;

  typedef struct packed {
    logic [`CLOU_DW-1:0] counter_value;
    logic                tick;
    logic [1:0]          count_mode;
  } clou_cnt_t;

endpackage

// ===== hw/clou_out_unit.sv
// Output unit of one channel
`timescale 1ns/100ps
`default_nettype none
`include "clou_defines.svh"

module clou_out_unit
  import clou_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic [2:0] waveform_select,
  input  wire logic       out_level,
  input  wire logic       channel_match_pulse,
  input  wire logic       period_match_pulse,
  output var  logic       channel_waveform
);

  // ----------------------------------------
  // Waveform generation
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      channel_waveform <= 1'b0;
    else
    begin
      unique case (waveform_select)
        `CLOU_WF_OUTPUT:  channel_waveform <= out_level;
        `CLOU_WF_SET:     if (channel_match_pulse) channel_waveform <= 1'b1;
        `CLOU_WF_TOG_RST:
          if (channel_match_pulse) channel_waveform <= ~channel_waveform;
          else if (period_match_pulse) channel_waveform <= 1'b0;
        `CLOU_WF_SET_RST:
          if (channel_match_pulse) channel_waveform <= 1'b1;
          else if (period_match_pulse) channel_waveform <= 1'b0;
        `CLOU_WF_TOGGLE:  if (channel_match_pulse) channel_waveform <= ~channel_waveform;
        `CLOU_WF_RESET:   if (channel_match_pulse) channel_waveform <= 1'b0;
        `CLOU_WF_TOG_SET:
          if (channel_match_pulse) channel_waveform <= ~channel_waveform;
          else if (period_match_pulse) channel_waveform <= 1'b1;
        `CLOU_WF_RST_SET:
          if (channel_match_pulse) channel_waveform <= 1'b0;
          else if (period_match_pulse) channel_waveform <= 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_wf_toggle;
    @(posedge clk_sys) disable iff (rst)
    (waveform_select == `CLOU_WF_TOGGLE) && channel_match_pulse
      |=> channel_waveform != $past(channel_waveform);
  endproperty
  a_wf_toggle: assert property (p_wf_toggle) else $error("toggle mode did not toggle");

  property p_wf_set;
    @(posedge clk_sys) disable iff (rst)
    (waveform_select == `CLOU_WF_SET) && channel_match_pulse |=> channel_waveform;
  endproperty
  a_wf_set: assert property (p_wf_set) else $error("set mode did not set");

  property p_wf_rst_set;
    @(posedge clk_sys) disable iff (rst)
    (waveform_select == `CLOU_WF_RST_SET) && period_match_pulse && !channel_match_pulse
      |=> channel_waveform;
  endproperty
  a_wf_rst_set: assert property (p_wf_rst_set) else $error("period match did not set");

  property p_wf_reset_hold;
    @(posedge clk_sys) disable iff (rst)
    (waveform_select == `CLOU_WF_RESET) && channel_match_pulse
      ##1 (waveform_select == `CLOU_WF_RESET) |-> !channel_waveform;
  endproperty
  a_wf_reset_hold: assert property (p_wf_reset_hold) else $error("reset mode not low");

endmodule // clou_out_unit

`default_nettype wire

// ===== hw/clou_top.sv
// Compare latches, capture triggers and output units of all channels
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "clou_defines.svh"

module clou_top
  import clou_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic [`CLOU_AW-1:0] reg_addr,
  input  wire logic [`CLOU_DW-1:0] reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output var  logic [`CLOU_DW-1:0] reg_rdata,
  input  wire clou_cnt_t           cnt,
  input  wire logic [`CLOU_NCH-1:0] cap_in_a,
  input  wire logic [`CLOU_NCH-1:0] cap_in_b,
  input  wire logic                outputs_hiz_pin,
  output var  logic [`CLOU_NCH-1:0] channel_waveform,
  output var  logic [`CLOU_NCH-1:0] waveform_oe_n,
  output var  logic [`CLOU_NCH-1:0] channel_match_flag
);

  // ----------------------------------------
  // Decoding functions
  // ----------------------------------------
  function automatic logic [`CLOU_NCH-1:0] ch_sel(
    input logic [`CLOU_AW-1:0] addr,
    input logic [`CLOU_AW-1:0] base
  );
    logic [`CLOU_NCH-1:0] hit;
    hit = '0;
    for (int i = 0; i < `CLOU_NCH; i++)
      hit[i] = (addr == base + `CLOU_AW'(i));
    return hit;
  endfunction

  function automatic logic [2:0] ctrl_of(
    input logic [2:0] ch,
    input logic [1:0] grp
  );
    logic [2:0] c;
    c = ch;
    unique case (grp)
      `CLOU_GRP_NONE:   c = ch;
      `CLOU_GRP_PAIR:   c = (ch == `CLOU_CH_ZERO || ch[0]) ? ch : ch - `CLOU_CH_ONE;
      `CLOU_GRP_TRIPLE:
        c = (ch == `CLOU_CH_ZERO) ? ch : (ch <= `CLOU_CH_THREE) ? `CLOU_CH_ONE : `CLOU_CH_FOUR;
      `CLOU_GRP_ALL:    c = `CLOU_CH_ONE;
    endcase
    return c;
  endfunction

  function automatic logic load_event(
    input logic [1:0]          tim,
    input clou_cnt_t           c,
    input logic [`CLOU_DW-1:0] per,
    input logic [`CLOU_DW-1:0] old
  );
    logic hit;
    hit = 1'b0;
    unique case (tim)
      `CLOU_LD_IMM:      hit = 1'b0;
      `CLOU_LD_ZERO:     hit = c.tick && (c.counter_value == `CLOU_ZERO_WORD);
      `CLOU_LD_ZERO_PER:
        hit = c.tick && ((c.counter_value == `CLOU_ZERO_WORD) ||
              ((c.count_mode == `CLOU_MC_UPDOWN) && (c.counter_value == per)));
      `CLOU_LD_OLD:      hit = c.tick && (c.counter_value == old);
    endcase
    return hit;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  clou_ctl_t            ctl          [`CLOU_NCH];
  clou_glb_t            glb;
  logic [`CLOU_DW-1:0]  channel_buffer [`CLOU_NCH];
  logic [`CLOU_DW-1:0]  shadow_latch   [`CLOU_NCH];
  logic [`CLOU_NCH-1:0] pending;
  logic [`CLOU_NCH-1:0] cap_a_s1;
  logic [`CLOU_NCH-1:0] cap_a_s2;
  logic [`CLOU_NCH-1:0] cap_b_s1;
  logic [`CLOU_NCH-1:0] cap_b_s2;
  logic [`CLOU_NCH-1:0] sel_prev;
  logic                 hiz_s1;
  logic                 hiz_s2;

  logic [`CLOU_NCH-1:0] wr_ctl;
  logic [`CLOU_NCH-1:0] wr_buf;
  logic                 wr_glb;
  logic [`CLOU_NCH-1:0] sel_sig;
  logic [`CLOU_NCH-1:0] capture;
  logic [`CLOU_NCH-1:0] channel_match_pulse;
  logic [`CLOU_NCH-1:0] load_imm;
  logic [`CLOU_NCH-1:0] load_grp;
  logic [`CLOU_NCH-1:0] grp_ready;
  logic [`CLOU_NCH-1:0] grp_event;
  logic [2:0]           ctrl [`CLOU_NCH];
  logic [`CLOU_DW-1:0]  next_rdata;
  clou_ctl_t            wr_view;

  assign wr_ctl  = reg_wr ? ch_sel(reg_addr, `CLOU_ADDR_CTL_BASE) : '0;
  assign wr_buf  = reg_wr ? ch_sel(reg_addr, `CLOU_ADDR_BUF_BASE) : '0;
  assign wr_glb  = reg_wr && (reg_addr == `CLOU_ADDR_GLB);
  assign wr_view = clou_ctl_t'(reg_wdata);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cap_a_s1 <= '0;
      cap_a_s2 <= '0;
      cap_b_s1 <= '0;
      cap_b_s2 <= '0;
      hiz_s1   <= 1'b0;
      hiz_s2   <= 1'b0;
    end
    else
    begin
      cap_a_s1 <= cap_in_a;
      cap_a_s2 <= cap_a_s1;
      cap_b_s1 <= cap_in_b;
      cap_b_s2 <= cap_b_s1;
      hiz_s1   <= outputs_hiz_pin;
      hiz_s2   <= hiz_s1;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      glb <= clou_glb_t'(`CLOU_ZERO_WORD);
      for (int k = 0; k < `CLOU_NCH; k++)
        ctl[k] <= clou_ctl_t'(`CLOU_ZERO_WORD);
    end
    else
    begin
      if (wr_glb)
        glb <= clou_glb_t'(reg_wdata);
      for (int k = 0; k < `CLOU_NCH; k++)
        if (wr_ctl[k])
          ctl[k] <= wr_view;
    end
  end

  // ----------------------------------------
  // Capture triggering
  // ----------------------------------------
  always_comb
  begin
    for (int k = 0; k < `CLOU_NCH; k++)
    begin
      unique case (ctl[k].input_source_select)
        `CLOU_SRC_A:   sel_sig[k] = cap_a_s2[k];
        `CLOU_SRC_B:   sel_sig[k] = cap_b_s2[k];
        `CLOU_SRC_GND: sel_sig[k] = 1'b0;
        `CLOU_SRC_VCC: sel_sig[k] = 1'b1;
      endcase
      capture[k] = ctl[k].sample_mode_select &&
        ((ctl[k].edge_select[0] && sel_sig[k] && !sel_prev[k]) ||
         (ctl[k].edge_select[1] && !sel_sig[k] && sel_prev[k]));
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      sel_prev <= '0;
    else
      sel_prev <= sel_sig;
  end

  // ----------------------------------------
  // Compare matching
  // ----------------------------------------
  always_comb
  begin
    for (int k = 0; k < `CLOU_NCH; k++)
      channel_match_pulse[k] = cnt.tick && !ctl[k].sample_mode_select &&
        (cnt.counter_value == shadow_latch[k]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      channel_match_flag <= '0;
    else
      for (int k = 0; k < `CLOU_NCH; k++)
        channel_match_flag[k] <= capture[k] || channel_match_pulse[k] ||
          (wr_ctl[k] ? wr_view.channel_match_flag : channel_match_flag[k]);
  end

  // ----------------------------------------
  // Latch load control
  // ----------------------------------------
  always_comb
  begin
    for (int k = 0; k < `CLOU_NCH; k++)
    begin
      ctrl[k]      = ctrl_of(3'(k), glb.latch_group_select);
      grp_event[k] = load_event(ctl[k].latch_load_timing, cnt,
                                shadow_latch[0], shadow_latch[k]);
      grp_ready[k] = 1'b1;
    end
    for (int j = 0; j < `CLOU_NCH; j++)
      for (int k = 0; k < `CLOU_NCH; k++)
        if ((ctrl[j] == 3'(k)) && !pending[j])
          grp_ready[k] = 1'b0;
    for (int k = 0; k < `CLOU_NCH; k++)
    begin
      load_imm[k] = wr_buf[k] &&
        (ctl[ctrl[k]].latch_load_timing == `CLOU_LD_IMM);
      load_grp[k] = (ctl[ctrl[k]].latch_load_timing != `CLOU_LD_IMM) &&
        grp_event[ctrl[k]] && grp_ready[ctrl[k]];
    end
  end

  // ----------------------------------------
  // Buffers and hidden latches
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      pending <= '0;
      for (int k = 0; k < `CLOU_NCH; k++)
      begin
        channel_buffer[k] <= `CLOU_ZERO_WORD;
        shadow_latch[k]   <= `CLOU_ZERO_WORD;
      end
    end
    else
    begin
      for (int k = 0; k < `CLOU_NCH; k++)
      begin
        if (capture[k])
          channel_buffer[k] <= cnt.counter_value;
        else if (wr_buf[k])
          channel_buffer[k] <= reg_wdata;
        if (load_imm[k] || (load_grp[k] && !wr_buf[k]))
          pending[k] <= 1'b0;
        else if (wr_buf[k])
          pending[k] <= 1'b1;
        if (load_imm[k])
          shadow_latch[k] <= reg_wdata;
        else if (load_grp[k])
          shadow_latch[k] <= channel_buffer[k];
      end
    end
  end

  // ----------------------------------------
  // Output units and pin enables
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CLOU_NCH; g++)
    begin : g_out
      clou_out_unit u_out (
        .clk_sys             (clk_sys),
        .rst                 (rst),
        .waveform_select     (ctl[g].waveform_select),
        .out_level           (ctl[g].out_level),
        .channel_match_pulse (channel_match_pulse[g]),
        .period_match_pulse  (channel_match_pulse[0]),
        .channel_waveform    (channel_waveform[g])
      );
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      waveform_oe_n <= '0;
    else
      waveform_oe_n <= {`CLOU_NCH{glb.hiz_function && hiz_s2}};
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always_comb
  begin
    clou_ctl_t view;
    view       = clou_ctl_t'(`CLOU_ZERO_WORD);
    next_rdata = `CLOU_ZERO_WORD;
    if (reg_addr == `CLOU_ADDR_GLB)
      next_rdata = glb;
    for (int k = 0; k < `CLOU_NCH; k++)
    begin
      if (reg_addr == `CLOU_ADDR_CTL_BASE + `CLOU_AW'(k))
      begin
        view                    = ctl[k];
        view.input_level        = sel_sig[k];
        view.channel_match_flag = channel_match_flag[k];
        next_rdata              = view;
      end
      if (reg_addr == `CLOU_ADDR_BUF_BASE + `CLOU_AW'(k))
        next_rdata = channel_buffer[k];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      reg_rdata <= `CLOU_ZERO_WORD;
    else
      reg_rdata <= reg_rd ? next_rdata : `CLOU_ZERO_WORD;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_sw_capture;
    @(posedge clk_sys) disable iff (rst)
    ctl[6].sample_mode_select && (ctl[6].edge_select == `CLOU_EDGE_BOTH) &&
    ctl[6].input_source_select[1] && $changed(ctl[6].input_source_select[0]) &&
    $stable(ctl[6].input_source_select[1])
      |=> channel_match_flag[6] && (channel_buffer[6] == $past(cnt.counter_value));
  endproperty
  a_sw_capture: assert property (p_sw_capture) else $error("software capture missed");

  property p_compare_only;
    @(posedge clk_sys) disable iff (rst)
    ctl[6].sample_mode_select |-> !channel_match_pulse[6];
  endproperty
  a_compare_only: assert property (p_compare_only) else $error("match in capture mode");

  property p_match_flag;
    @(posedge clk_sys) disable iff (rst)
    cnt.tick && !ctl[2].sample_mode_select && (cnt.counter_value == shadow_latch[2])
      |=> channel_match_flag[2];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match flag not set");

  property p_imm_load;
    @(posedge clk_sys) disable iff (rst)
    wr_buf[3] && (glb.latch_group_select == `CLOU_GRP_NONE) &&
    (ctl[3].latch_load_timing == `CLOU_LD_IMM)
      |=> shadow_latch[3] == $past(reg_wdata);
  endproperty
  a_imm_load: assert property (p_imm_load) else $error("immediate load missed");

  property p_zero_load;
    @(posedge clk_sys) disable iff (rst)
    (glb.latch_group_select == `CLOU_GRP_NONE) && (ctl[2].latch_load_timing == `CLOU_LD_ZERO) &&
    pending[2] && cnt.tick && (cnt.counter_value == `CLOU_ZERO_WORD) && !capture[2]
      |=> (shadow_latch[2] == $past(channel_buffer[2])) && !$changed(channel_buffer[2]);
  endproperty
  a_zero_load: assert property (p_zero_load) else $error("zero load missed");

  property p_group_wait;
    @(posedge clk_sys) disable iff (rst)
    (glb.latch_group_select == `CLOU_GRP_PAIR) && !pending[4] && !wr_buf[3]
      |=> $stable(shadow_latch[3]);
  endproperty
  a_group_wait: assert property (p_group_wait) else $error("group loaded early");

  property p_hiz;
    @(posedge clk_sys) disable iff (rst)
    glb.hiz_function && hiz_s2 |=> (&waveform_oe_n);
  endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not floated");

  property p_mode0;
    @(posedge clk_sys) disable iff (rst)
    (ctl[5].waveform_select == `CLOU_WF_OUTPUT) |=> channel_waveform[5] == $past(ctl[5].out_level);
  endproperty
  a_mode0: assert property (p_mode0) else $error("mode 0 output wrong");

  c_sw_capture: cover property (@(posedge clk_sys) disable iff (rst) capture[6]);
  c_group_load: cover property (@(posedge clk_sys) disable iff (rst)
    (glb.latch_group_select == `CLOU_GRP_TRIPLE) && load_grp[4]);
  c_toggle: cover property (@(posedge clk_sys) disable iff (rst)
    (ctl[3].waveform_select == `CLOU_WF_TOGGLE) && channel_match_pulse[3]);

endmodule // clou_top

`default_nettype wire

// ===== dv/clou_pins.sv
// Pin and capture input model of the timer's far side
`timescale 1ns/100ps
`default_nettype none

module clou_pins
  import clou_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       hiz_req,
  input  wire logic [6:0] wave,
  input  wire logic [6:0] oe_n,
  output var  logic       outputs_hiz_pin,
  output var  logic [6:0] cap_in_a,
  output var  logic [6:0] cap_in_b,
  output var  logic [6:0] pad
);
  // Floated pads pulled low
  always_comb pad = wave & ~oe_n;
  // Pin driven from outside, one flop late
  always_ff @(posedge clk_sys) outputs_hiz_pin <= hiz_req;
  always_comb cap_in_a = pad;
  always_comb cap_in_b = ~pad;
endmodule // clou_pins

`default_nettype wire

// ===== dv/compare_latch_output_unit_tb_top.sv
// Testbench of the compare latch and output unit
`timescale 1ns/100ps
`default_nettype none

module compare_latch_output_unit_tb_top
  import clou_pkg::*;
;
  logic        clk_sys = 1'h0;
  logic        rst = 1'h1;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [15:0] reg_rdata;
  clou_cnt_t   cnt = '0;
  logic        hiz_req = 1'h0;
  logic        hz;
  logic [6:0]  cia, cib, wave, oe_n, flag, pad;
  int          n_mismatch = 0;
  int          n_checks = 0;

  always #20 clk_sys = ~clk_sys;

  clou_top u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cnt(cnt), .cap_in_a(cia), .cap_in_b(cib),
    .outputs_hiz_pin(hz), .channel_waveform(wave), .waveform_oe_n(oe_n),
    .channel_match_flag(flag));
  clou_pins u_pins (.clk_sys(clk_sys), .hiz_req(hiz_req), .wave(wave),
    .oe_n(oe_n), .outputs_hiz_pin(hz), .cap_in_a(cia), .cap_in_b(cib),
    .pad(pad));

  // ----------------------------------------
  // Bus, counter and compare helpers
  // ----------------------------------------
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
    @(posedge clk_sys);
  endtask

  task cb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [4:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(negedge clk_sys);
    chk("rdata", e, reg_rdata);
  endtask

  task tk(input logic [15:0] v, input logic [1:0] m);
    cnt <= {v, 1'h1, m};
    @(posedge clk_sys);
    cnt.tick <= 1'h0;
    repeat (2) @(posedge clk_sys);
  endtask

  function logic [15:0] ctl(input logic [2:0] md, input logic [1:0] tm, input logic ol);
    return {5'h00, tm, 1'h0, md, 3'h0, ol, 1'h0};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd(5'h01, 16'h0000);
    rd(5'h09, 16'h0000);
    chk("wave", 16'h0000, {9'h000, wave});
  endtask

  task t_toggle;
    wr(5'h01, ctl(3'h4, 2'h0, 1'h0));
    wr(5'h09, 16'h0005);
    tk(16'h0005, 2'h0);
    cb("wave1", 1'h1, wave[1]);
    cb("flag1", 1'h1, flag[1]);
    tk(16'h0005, 2'h3);
    cb("wave1", 1'h0, wave[1]);
    rd(5'h18, 16'h0000);
  endtask

  task t_tim01;
    wr(5'h02, ctl(3'h4, 2'h1, 1'h0));
    wr(5'h0A, 16'h0007);
    tk(16'h0007, 2'h0);
    cb("wave2", 1'h0, wave[2]);
    tk(16'h0000, 2'h0);
    tk(16'h0007, 2'h0);
    cb("wave2", 1'h0, wave[2]);
  endtask

  task t_group;
    wr(5'h03, ctl(3'h4, 2'h0, 1'h0));
    wr(5'h04, ctl(3'h4, 2'h0, 1'h0));
    wr(5'h0B, 16'h0064);
    wr(5'h0C, 16'h0064);
    wr(5'h10, 16'h0001);
    wr(5'h03, ctl(3'h4, 2'h1, 1'h0));
    wr(5'h0B, 16'h0009);
    tk(16'h0000, 2'h0);
    tk(16'h0009, 2'h0);
    cb("wave3", 1'h0, wave[3]);
    wr(5'h0C, 16'h0009);
    tk(16'h0009, 2'h0);
    cb("wave4", 1'h0, wave[4]);
    tk(16'h0000, 2'h0);
    tk(16'h0009, 2'h0);
    chk("wave34", 16'h0003, {14'h0000, wave[4:3]});
    wr(5'h10, 16'h0000);
  endtask

  task t_modes;
    wr(5'h08, 16'h001E);
    wr(5'h0D, 16'h0014);
    for (int m = 1; m < 8; m++)
    begin
      wr(5'h05, ctl(3'h0, 2'h0, 1'(8'hA0 >> m)));
      @(negedge clk_sys);
      cb("mode0", 1'(8'hA0 >> m), wave[5]);
      wr(5'h05, ctl(3'h7, 2'h0, 1'h0));
      wr(5'h05, ctl(m[2:0], 2'h0, 1'h0));
      tk(16'h0014, 2'h0);
      cb("chan", 1'(8'h5E >> m), wave[5]);
      tk(16'h001E, 2'h0);
      cb("period", 1'(8'hD2 >> m), wave[5]);
    end
  endtask

  task t_loads;
    wr(5'h02, ctl(3'h4, 2'h2, 1'h0));
    wr(5'h0A, 16'h0044);
    tk(16'h001E, 2'h0);
    tk(16'h0044, 2'h0);
    cb("wave2", 1'h0, wave[2]);
    tk(16'h001E, 2'h3);
    tk(16'h0044, 2'h0);
    cb("wave2", 1'h1, wave[2]);
    wr(5'h10, 16'h0002);
    wr(5'h04, ctl(3'h4, 2'h3, 1'h0));
    wr(5'h0C, 16'h0030);
    wr(5'h0D, 16'h0030);
    tk(16'h0009, 2'h0);
    cb("wave4", 1'h0, wave[4]);
    wr(5'h0E, 16'h0030);
    tk(16'h0009, 2'h0);
    cb("wave4", 1'h1, wave[4]);
    tk(16'h0030, 2'h0);
    chk("wave54", 16'h0000, {14'h0000, wave[5:4]});
  endtask

  task t_capture;
    wr(5'h06, 16'hF100);
    cnt <= {16'h1234, 1'h0, 2'h0};
    wr(5'h06, 16'hE100);
    rd(5'h0E, 16'h1234);
    cb("flag6", 1'h1, flag[6]);
    cnt <= {16'h4321, 1'h0, 2'h0};
    wr(5'h06, 16'hF100);
    rd(5'h0E, 16'h4321);
  endtask

  task t_hiz;
    wr(5'h10, 16'h0004);
    hiz_req <= 1'h1;
    repeat (5) @(posedge clk_sys);
    chk("oe_n", 16'h007F, {9'h000, oe_n});
    hiz_req <= 1'h0;
    repeat (5) @(posedge clk_sys);
    chk("oe_n", 16'h0000, {9'h000, oe_n});
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    @(posedge clk_sys);
    t_reset();
    t_toggle();
    t_tim01();
    t_group();
    t_modes();
    t_loads();
    t_capture();
    t_hiz();
    summarize();
  end

  initial
  begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule // compare_latch_output_unit_tb_top

`default_nettype wire
